// ==== hdl/cas_alarm_status.sv ====
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// - lane fifo over/underflow sets bit 5
// - pll out of lock sets bit 4
// - 8b/10b: link enabled, not encoding, sets bit 3
// - 64b/66b: start or realignment sets bit 3
// - sysref clock realignment sets bit 2
// - link disabled, nco synced, or mismatch sets bit 1
// - divider mismatch between channels sets bit 0
// - write one clears flag; reset value 0x3f
// - power-on or soft reset forces flags high
// - link disabled: only clock alarm defined
// - per-lane field records offending fifo lane
// - summary bit high on unmasked set flag
// - mask bit hides flag; masks reset one
// - clearing fifo flag clears per-lane field
module cas_alarm_status (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  softReset,
  input  wire cas_pkg::cas_cond_type cond,
  input  wire logic [13:0]           avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       cal_status_pin,
  output logic                       alarmIrq
);
  import cas_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  cas_cond_type  condSync1;        // first stage, only read by stage two
  cas_cond_type  condSync2;        // synchronized alarm conditions
  logic          busy_reg;         // one wait cycle per access
  logic [5:0]    flags;            // alarm_flags
  logic [5:0]    flagSet;          // hardware set terms
  logic [5:0]    flagClr;          // software clear terms
  logic [5:0]    alarm_enable_mask_reg; // alarm mask
  logic [15:0]   lane_reg;         // per_lane_buffer_alarms
  logic [15:0]   lane_next;
  logic [2:0]    ctrl_reg;         // link enable, mode, pin select
  logic          linkEn;           // serial_link_enable
  logic          summary;          // unmasked alarm present
  logic [5:0]    irqStatus;        // sticky event bits
  logic [5:0]    irq_en_reg;       // interrupt enable
  logic [5:0]    flagsPrev_reg;    // for rising-edge events
  logic          lowByte;          // byte lane 0 enabled
  logic          wrHit;            // write accepted this cycle
  logic [11:0]   index;            // register index
  logic          anyRst;           // hard or soft reset

  assign anyRst  = rst | softReset;
  assign index   = avs_address[13:2];
  assign lowByte = avs_byteenable[0];
  assign wrHit   = avs_write & busy_reg;
  assign linkEn  = ctrl_reg[CTRL_LINK_EN];

  // ****************************************************************
  // input synchronizers for external conditions
  // ****************************************************************
  // the back end runs on other clocks, so every condition passes
  // two flops; the alarm flags therefore lag their cause by three cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      condSync1 <= '0;
      condSync2 <= '0;
    end else begin
      condSync1 <= cond;
      condSync2 <= condSync1;
    end
  end

  // ****************************************************************
  // avalon slave handshake: waitrequest low on second cycle
  // ****************************************************************
  // busy marks the answering cycle, so a request still held
  // there is not taken a second time
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if ((avs_read | avs_write) & ~busy_reg) begin
      busy_reg <= 1'b1;            // answer on next edge
    end else begin
      busy_reg <= 1'b0;
    end
  end

  // waitrequest high unless answering
  // registered so that the port comes straight from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~busy_reg);
    end
  end

  // ****************************************************************
  // alarm set conditions
  // ****************************************************************
  always_comb begin
    flagSet = '0;
    flagSet[BIT_FIFO]    = |(condSync2.laneFifoErr);
    flagSet[BIT_PLL]     = condSync2.pllUnlocked;
    if (!ctrl_reg[CTRL_MODE_66]) begin
      flagSet[BIT_LINK]  = linkEn & ~condSync2.txInDataState;
    end else begin
      flagSet[BIT_LINK]  = condSync2.linkStart |
                           condSync2.realignEvent;
    end
    flagSet[BIT_REALIGN] = condSync2.sysrefRealign;
    flagSet[BIT_NCO]     = ~linkEn | condSync2.ncoSync |
                           condSync2.ncoMismatch;
    flagSet[BIT_CLK]     = condSync2.divMismatch;
  end

  // write-one-to-clear of alarm_flags; byte lane 0 carries the bits
  // reserved bits 7:6 are ignored on write
  always_comb begin
    flagClr = '0;
    if (wrHit && lowByte && index == 12'(IDX_ALARM_FLAGS)) begin
      flagClr = avs_writedata[5:0];
    end
  end

  // ****************************************************************
  // sticky flags, one cell per alarm
  // ****************************************************************
  // while the link is disabled the non-clock flags are undefined;
  // here they simply follow their set terms
  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g++) begin : gFlag
      cas_sticky_bit #(
        .RESET_VAL (FLAGS_RESET[g])
      ) uFlag (
        .clk     (clk),
        .rst     (anyRst),
        .setIn   (flagSet[g]),
        .clrIn   (flagClr[g]),
        .flagOut (flags[g])
      );
    end
  endgenerate

  // ****************************************************************
  // per-lane fifo alarm field
  // ****************************************************************
  always_comb begin
    lane_next = lane_reg;
    if (wrHit && index == 12'(IDX_LANE_ALARMS)) begin
      if (avs_byteenable[0]) begin
        lane_next[7:0]  = lane_reg[7:0] & ~avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        lane_next[15:8] = lane_reg[15:8] & ~avs_writedata[15:8];
      end
    end
    if (flagClr[BIT_FIFO]) begin
      lane_next = '0;
    end
    // lane errors are or-ed in last, so a persisting error
    // survives a clear in the same cycle
    lane_next = lane_next | condSync2.laneFifoErr;
  end

  // per-lane storage
  always_ff @(posedge clk) begin
    if (anyRst) begin
      lane_reg <= LANE_RESET;
    end else begin
      lane_reg <= lane_next;
    end
  end

  // ****************************************************************
  // mask and control registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (anyRst) begin
      alarm_enable_mask_reg <= MASK_RESET;
    end else if (wrHit && lowByte && index == 12'(IDX_ALARM_MASK)) begin
      alarm_enable_mask_reg <= avs_writedata[5:0];
    end
  end

  // link control: enable, coding mode, cal pin select
  // bit 2 only gates the pin; the summary register is always live
  always_ff @(posedge clk) begin
    if (anyRst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrHit && lowByte && index == 12'(IDX_LINK_CTRL)) begin
      ctrl_reg <= avs_writedata[2:0];
    end
  end

  // ****************************************************************
  // summary alarm and status pin
  // ****************************************************************
  // masked flags still read back in alarm_flags
  assign summary = |(flags & ~alarm_enable_mask_reg);

  // cal status pin shows the summary when selected
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_status_pin <= 1'b0;
    end else begin
      cal_status_pin <= ctrl_reg[CTRL_CAL_SEL] & summary;
    end
  end

  // ****************************************************************
  // interrupt status: rising edge of each flag is an event
  // ****************************************************************
  // history resets to the flags' own reset value, so no false
  // event follows a hard reset
  always_ff @(posedge clk) begin
    if (rst) begin
      flagsPrev_reg <= FLAGS_RESET;
    end else begin
      flagsPrev_reg <= flags;
    end
  end

  // sticky events; set wins over the write-only clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= '0;
    end else begin
      if (wrHit && lowByte && index == 12'(IDX_IRQ_CLEAR)) begin
        irqStatus <= (irqStatus & ~avs_writedata[5:0]) |
                     (flags & ~flagsPrev_reg);
      end else begin
        irqStatus <= irqStatus | (flags & ~flagsPrev_reg);
      end
    end
  end

  // irq enable register
  // soft reset leaves the interrupt registers alone
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg <= IRQ_EN_RESET;
    end else if (wrHit && lowByte && index == 12'(IDX_IRQ_ENABLE)) begin
      irq_en_reg <= avs_writedata[5:0];
    end
  end

  // level interrupt output
  always_ff @(posedge clk) begin
    if (rst) begin
      alarmIrq <= 1'b0;
    end else begin
      alarmIrq <= |(irqStatus & irq_en_reg);
    end
  end

  // ****************************************************************
  // read data, registered on the answering edge
  // ****************************************************************
  // reserved upper bits always read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if ((avs_read) & ~busy_reg) begin
      case (index)
        12'(IDX_ALARM_SUMMARY): avs_readdata <= {31'h0, summary};
        12'(IDX_ALARM_FLAGS):   avs_readdata <= {26'h0, flags};
        12'(IDX_ALARM_MASK):
          avs_readdata <= {26'h0, alarm_enable_mask_reg};
        12'(IDX_LANE_ALARMS):   avs_readdata <= {16'h0, lane_reg};
        12'(IDX_LINK_CTRL):     avs_readdata <= {29'h0, ctrl_reg};
        12'(IDX_IRQ_STATUS):    avs_readdata <= {26'h0, irqStatus};
        12'(IDX_IRQ_ENABLE):    avs_readdata <= {26'h0, irq_en_reg};
        default:                avs_readdata <= 32'h0; // unmapped reads zero
      endcase
    end
  end

endmodule : cas_alarm_status

// ==== hdl/cas_pkg.sv ====
package cas_pkg;

  // ****************************************************************
  // register map (printed offsets are indices; byte address = 4*index)
  // ****************************************************************
  localparam int          IDX_ALARM_SUMMARY  = 'h2c0; // read-only summary
  localparam int          IDX_ALARM_FLAGS    = 'h2c1; // sticky w1c flags
  localparam int          IDX_ALARM_MASK     = 'h2c2; // alarm mask
  localparam int          IDX_LANE_ALARMS    = 'h2c4; // per-lane w1c
  localparam int          IDX_LINK_CTRL      = 'h2d0; // link enable, mode
  localparam int          IDX_IRQ_STATUS     = 'h2d1; // sticky event bits
  localparam int          IDX_IRQ_CLEAR      = 'h2d2; // write-only clear
  localparam int          IDX_IRQ_ENABLE     = 'h2d3; // irq enable
  localparam int          ADDR_W             = 12;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          BIT_FIFO           = 5;
  localparam int          BIT_PLL            = 4;
  localparam int          BIT_LINK           = 3;
  localparam int          BIT_REALIGN        = 2;
  localparam int          BIT_NCO            = 1;
  localparam int          BIT_CLK            = 0;
  localparam int          NUM_ALARMS         = 6;
  localparam int          CTRL_LINK_EN       = 0;  // serial_link_enable
  localparam int          CTRL_MODE_66       = 1;  // 1: 64b/66b, 0: 8b/10b
  localparam int          CTRL_CAL_SEL       = 2;  // route summary to pin

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0]  FLAGS_RESET        = 6'h3f;
  localparam logic [5:0]  MASK_RESET         = 6'h3f;
  localparam logic [15:0] LANE_RESET         = 16'hffff;
  localparam logic [2:0]  CTRL_RESET         = 3'h0;
  localparam logic [5:0]  IRQ_EN_RESET       = 6'h00;

  // ****************************************************************
  // alarm condition inputs from the converter back end
  // ****************************************************************
  typedef struct packed {
    logic [15:0] laneFifoErr;   // per-lane overflow/underflow
    logic        pllUnlocked;   // pll out of lock
    logic        txInDataState; // transmitter in data-encoding state
    logic        linkStart;     // 64b/66b link start pulse
    logic        realignEvent;  // fifo/serializer realignment pulse
    logic        sysrefRealign; // sysref realigned internal clocks
    logic        ncoSync;       // oscillators synchronized
    logic        ncoMismatch;   // channel a/b accumulators differ
    logic        divMismatch;   // channel a/b dividers differ
  } cas_cond_type;

endpackage : cas_pkg

// ==== hdl/cas_sticky_bit.sv ====
`timescale 1ns/1ps
// one sticky flag: hardware set wins over software clear
module cas_sticky_bit #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic setIn,
  input  wire logic clrIn,
  output logic      flagOut
);

  // ****************************************************************
  // flag storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      flagOut <= RESET_VAL;        // forced after reset
    end else if (setIn) begin
      flagOut <= 1'b1;             // set beats a same-cycle clear
    end else if (clrIn) begin
      flagOut <= 1'b0;
    end
  end

endmodule : cas_sticky_bit

// ==== verif/cas_alarm_status_sva.sv ====
`timescale 1ns/1ps
// ****************************************************************
// port checker for the alarm block
// ****************************************************************
module cas_alarm_status_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [13:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        alarmIrq,
  input wire logic        cal_status_pin
);
  import cas_pkg::*;
  logic [11:0] regIdx; // word index of the request
  logic        rdAck;  // read answered in this cycle
  assign regIdx = avs_address[13:2];
  assign rdAck  = avs_read && !avs_waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wait_one_state: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_ack_one_cycle: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_idle_waits: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without a request");
  a_unmapped_zero: assert property (
    rdAck && regIdx == 12'h2c3 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_flags_width: assert property (
    rdAck && regIdx == 12'(IDX_ALARM_FLAGS) |-> avs_readdata[31:6] == 0)
    else $error("flag word has bits above the six alarms");
  a_mask_width: assert property (
    rdAck && regIdx == 12'(IDX_ALARM_MASK) |-> avs_readdata[31:6] == 0)
    else $error("mask word has bits above the six alarms");
  a_summary_width: assert property (
    rdAck && regIdx == 12'(IDX_ALARM_SUMMARY) |-> avs_readdata[31:1] == 0)
    else $error("summary word wider than one bit");
  a_rdata_holds: assert property (
    !$stable(avs_readdata) |-> rdAck)
    else $error("read data changed outside a read answer");
  a_reset_quiet: assert property (
    $fell(rst) |-> avs_waitrequest && !alarmIrq && !cal_status_pin)
    else $error("outputs active straight after reset");
endmodule : cas_alarm_status_sva

bind cas_alarm_status cas_alarm_status_sva u_sva (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .alarmIrq(alarmIrq),
  .cal_status_pin(cal_status_pin));

// ==== verif/cas_alarm_status_tb.sv ====
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the alarm block
// ****************************************************************
module cas_alarm_status_tb;
  import cas_pkg::*;
  localparam cas_cond_type IDLE = '{txInDataState: 1'b1, default: '0};
  localparam int BIT_OF[9] = '{BIT_FIFO, BIT_PLL, BIT_LINK, BIT_LINK,
    BIT_LINK, BIT_REALIGN, BIT_NCO, BIT_NCO, BIT_CLK};
  logic         clk, rst, softReset, avs_read, avs_write;
  logic         avs_waitrequest, cal_status_pin, alarmIrq;
  logic [13:0]  avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  logic [3:0]   avs_byteenable;
  cas_cond_type cond;                // back-end alarm conditions
  int           nMismatch, samplesChecked, cyc;

  cas_alarm_status DUT (.clk(clk), .rst(rst), .softReset(softReset),
    .cond(cond), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cal_status_pin(cal_status_pin),
    .alarmIrq(alarmIrq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: whole run needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (nMismatch == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input int idx, input logic [31:0] wd);
    avs_address   <= 14'(idx * 4);
    avs_writedata <= wd;
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge clk);
    // wait for the answer; only the bench timeout ends a hang
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input int idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr
  task automatic rdchk(input int idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask : rdchk
  // one alarm condition per case of the event table
  function automatic cas_cond_type condFor(input int i);
    cas_cond_type c;
    c = IDLE;
    case (i)
      0: c.laneFifoErr[3] = 1'b1;
      1: c.pllUnlocked = 1'b1;
      2: c.txInDataState = 1'b0;
      3: c.linkStart = 1'b1;
      4: c.realignEvent = 1'b1;
      5: c.sysrefRealign = 1'b1;
      6: c.ncoSync = 1'b1;
      7: c.ncoMismatch = 1'b1;
      default: c.divMismatch = 1'b1;
    endcase
    return c;
  endfunction : condFor

  task automatic t_reset;
    rdchk(IDX_ALARM_FLAGS, 32'h3f);
    rdchk(IDX_ALARM_MASK, 32'h3f);
    rdchk(IDX_LANE_ALARMS, 32'hffff);
    rdchk(IDX_ALARM_SUMMARY, 32'h0);
    rdchk('h2c3, 32'h0);
  endtask : t_reset
  task automatic t_events;
    logic [31:0] ex; // expected flag word
    for (int i = 0; i < 9; i++) begin
      wr(IDX_LINK_CTRL, (i == 3 || i == 4) ? 32'h3 : 32'h1);
      tick(5);
      wr(IDX_ALARM_FLAGS, 32'h3f);
      rdchk(IDX_ALARM_FLAGS, 32'h0);
      cond <= condFor(i);
      tick(1);
      cond <= IDLE;
      tick(6);
      ex = 32'h1 << BIT_OF[i];
      rdchk(IDX_ALARM_FLAGS, ex);
      if (i == 0) rdchk(IDX_LANE_ALARMS, 32'h8);
      wr(IDX_ALARM_FLAGS, ex);
      rdchk(IDX_ALARM_FLAGS, 32'h0);
      if (i == 0) rdchk(IDX_LANE_ALARMS, 32'h0);
    end
  endtask : t_events
  task automatic t_mask;
    wr(IDX_LINK_CTRL, 32'h5);
    cond.pllUnlocked <= 1'b1;
    tick(5);
    wr(IDX_ALARM_FLAGS, 32'h10);
    rdchk(IDX_ALARM_FLAGS, 32'h10);
    rdchk(IDX_ALARM_SUMMARY, 32'h0);
    check({31'h0, cal_status_pin}, 32'h0);
    wr(IDX_ALARM_MASK, 32'h2f);
    rdchk(IDX_ALARM_MASK, 32'h2f);
    rdchk(IDX_ALARM_SUMMARY, 32'h1);
    check({31'h0, cal_status_pin}, 32'h1);
    cond.pllUnlocked <= 1'b0;
    tick(5);
    wr(IDX_ALARM_FLAGS, 32'h10);
    tick(2);
    rdchk(IDX_ALARM_SUMMARY, 32'h0);
  endtask : t_mask
  // irq: raise, mask, unmask, clear
  task automatic t_irq;
    wr(IDX_IRQ_CLEAR, 32'h3f);
    wr(IDX_IRQ_ENABLE, 32'h10);
    check({31'h0, alarmIrq}, 32'h0);
    cond.pllUnlocked <= 1'b1;
    tick(1);
    cond.pllUnlocked <= 1'b0;
    tick(6);
    check({31'h0, alarmIrq}, 32'h1);
    rdchk(IDX_IRQ_STATUS, 32'h10);
    wr(IDX_IRQ_ENABLE, 32'h0);
    tick(2);
    check({31'h0, alarmIrq}, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h10);
    tick(2);
    check({31'h0, alarmIrq}, 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h10);
    tick(2);
    check({31'h0, alarmIrq}, 32'h0);
  endtask : t_irq
  // link off: oscillator alarm stays, clock alarm still clears
  task automatic t_link_off;
    wr(IDX_LINK_CTRL, 32'h0);
    tick(6);
    wr(IDX_ALARM_FLAGS, 32'h3f);
    tick(1);
    bus(1'b0, IDX_ALARM_FLAGS, 32'h0);
    check(rd & 32'h3, 32'h2);
    softReset <= 1'b1;
    tick(1);
    softReset <= 1'b0;
    rdchk(IDX_ALARM_FLAGS, 32'h3f);
    rdchk(IDX_ALARM_MASK, 32'h3f);
    rdchk(IDX_LANE_ALARMS, 32'hffff);
    // flags forced high by soft reset rise, an enabled irq event
    check({31'h0, alarmIrq}, 32'h1);
  endtask : t_link_off
  // byte lanes: lane field clears per bit, 8-bit registers need lane 0
  task automatic t_bytes;
    avs_byteenable <= 4'h2;
    wr(IDX_LANE_ALARMS, 32'h0f0f);
    wr(IDX_ALARM_MASK, 32'h0);
    avs_byteenable <= 4'hf;
    rdchk(IDX_LANE_ALARMS, 32'hf0ff);
    rdchk(IDX_ALARM_MASK, 32'h3f);
  endtask : t_bytes

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    softReset = 1'b0;
    cond = IDLE;
    avs_address = 14'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    tick(3);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_mask();
    t_irq();
    t_link_off();
    t_bytes();
    end_sim();
  end
endmodule : cas_alarm_status_tb
